// ===== hw/i2cs_port.sv
// two-wire slave command port: framing, addressing, command intake, pointer reads
//
// Behaviour
// - bytes move msb first, each followed by one acknowledge bit.
// - sda falling while scl high starts a frame.
// - sda rising while scl high ends the frame.
// - a start without preceding stop begins a new transfer.
// - sda changes only while scl low, except start and stop.
// - received bits are taken on scl rising, one pulse per bit.
// - transmitted bits change after scl falling, valid at next rise.
// - an acknowledging receiver holds sda low through the ack high phase.
// - respond only when the upper seven address bits match.
// - address lsb zero means write, one means read.
// - refused bytes are left unacknowledged with sda released.
// - master nack on a read makes the device release sda.
// - first write byte is a command, maybe followed by a parameter.
// - ack valid codes and expected parameters, never surplus or invalid.
// - reads return the pointed register, repeated on every byte.
// - decode device reset, set read pointer and write configuration.
// - decode line reset, single bit and write byte.
// - decode line read byte, triplet and port adjust.
// - works at 100 and 400 kbps bus rates.
// - line commands are refused while the line busy flag is set.
`timescale 1ns/1ns
`include "i2cs_map.svh"
module i2cs_port
  import i2cs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary value, set per build
  parameter logic [7:0] PTR_RESET = 8'h00
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // two-wire bus pins (sda is open drain)
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // single-wire side state
  input wire logic line_busy_flag,
  // parameter check by the register side
  output logic [7:0] param_code,
  output logic [7:0] param_byte,
  input wire logic param_ok,
  // accepted command
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_param,
  output logic cmd_has_param,
  output logic device_reset,
  // read path
  output logic [7:0] read_pointer,
  input wire logic [7:0] read_data
);
  import i2cs_pkg::*;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  i2cs_if bus_if ();

  i2cs_line_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(bus_if.sync)
  );

  i2cs_cmd_dec u_dec (
    .dc(bus_if.dec)
  );

  i2cs_core_t r;
  i2cs_core_t next_r;

  // the byte just shifted in is the candidate command code
  assign bus_if.code = r.shreg;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] bit_inc(input logic [3:0] c);
    bit_inc = c + 4'h1;
  endfunction

  function automatic logic byte_done(input logic [3:0] c);
    byte_done = (c == `I2CS_BITS_PER_BYTE);
  endfunction

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.cmd_strobe = 1'b0;
    next_r.dev_reset = 1'b0;

    if (bus_if.stop) begin
      // stop ends everything, partial byte dropped
      next_r.st = I2CS_IDLE;
      next_r.sda_drive = 1'b0;
      next_r.ack_phase = 1'b0;
      next_r.bitcnt = `I2CS_BIT_ZERO;
    end else if (bus_if.start) begin
      // start or repeated start always rearms address intake
      next_r.st = I2CS_ADDR;
      next_r.sda_drive = 1'b0;
      next_r.ack_phase = 1'b0;
      next_r.bitcnt = `I2CS_BIT_ZERO;
    end else if (r.st == I2CS_IDLE || r.st == I2CS_IGNORE) begin
      // stay off the bus until the next start; sda left high
      next_r.sda_drive = 1'b0;
    end else if (bus_if.scl_rise) begin
      if (!r.ack_phase) begin
        if (r.st != I2CS_R_DATA) begin
          // one shift per scl pulse, msb arrives first
          next_r.shreg = {r.shreg[6:0], bus_if.sda_in};
        end
        next_r.bitcnt = bit_inc(r.bitcnt);
      end else if (r.st == I2CS_R_DATA) begin
        next_r.master_nack = bus_if.sda_in;
      end
    end else if (bus_if.scl_fall) begin
      // every sda change is made just after scl falls
      if (r.ack_phase) begin
        next_r.ack_phase = 1'b0;
        next_r.bitcnt = `I2CS_BIT_ZERO;
        if (r.st == I2CS_R_DATA) begin
          if (r.master_nack) begin
            next_r.st = I2CS_IGNORE;
            next_r.sda_drive = 1'b0;
          end else begin
            // same pointed register again, msb out first
            next_r.shreg = read_data;
            next_r.sda_drive = ~read_data[7];
          end
        end else begin
          next_r.sda_drive = 1'b0;
        end
      end else if (r.st == I2CS_R_DATA) begin
        if (byte_done(r.bitcnt)) begin
          // free sda for the master's acknowledge
          next_r.sda_drive = 1'b0;
          next_r.ack_phase = 1'b1;
          next_r.master_nack = 1'b1;
        end else begin
          next_r.shreg = {r.shreg[6:0], 1'b0};
          next_r.sda_drive = ~r.shreg[6];
        end
      end else if (byte_done(r.bitcnt)) begin
        next_r.ack_phase = 1'b1;
        next_r.sda_drive = 1'b0;
        case (r.st)
          I2CS_ADDR: begin
            if (r.shreg[7:1] == SLAVE_ADDR) begin
              next_r.sda_drive = 1'b1;
              next_r.master_nack = 1'b0;
              if (r.shreg[0] == `I2CS_DIR_READ) begin
                next_r.st = I2CS_R_DATA;
              end else begin
                next_r.st = I2CS_W_CMD;
              end
            end else begin
              next_r.st = I2CS_IGNORE;
            end
          end
          I2CS_W_CMD: begin
            if (bus_if.known && !(bus_if.busy_check && line_busy_flag)) begin
              next_r.sda_drive = 1'b1;
              next_r.pend_code = r.shreg;
              if (bus_if.has_param) begin
                next_r.st = I2CS_W_PARAM;
              end else begin
                next_r.st = I2CS_W_SURPLUS;
                next_r.cmd_strobe = 1'b1;
                next_r.cmd_code = r.shreg;
                next_r.cmd_has_param = 1'b0;
                if (r.shreg == `I2CS_CMD_DEVICE_RESET) begin
                  next_r.dev_reset = 1'b1;
                  next_r.rd_ptr = PTR_RESET;
                end
              end
            end else begin
              next_r.st = I2CS_IGNORE;
            end
          end
          I2CS_W_PARAM: begin
            if (param_ok) begin
              next_r.sda_drive = 1'b1;
              next_r.st = I2CS_W_SURPLUS;
              next_r.cmd_strobe = 1'b1;
              next_r.cmd_code = r.pend_code;
              next_r.cmd_param = r.shreg;
              next_r.cmd_has_param = 1'b1;
              if (r.pend_code == `I2CS_CMD_SET_READ_POINTER) begin
                next_r.rd_ptr = r.shreg;
              end
            end else begin
              next_r.st = I2CS_IGNORE;
            end
          end
          default: begin
            // surplus bytes are never acknowledged
            next_r.st = I2CS_IGNORE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // sampling at 100 MHz leaves over a hundred samples per scl half
  // period even at fast rate, so no extra filtering is needed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r.st <= I2CS_IDLE;
      r.bitcnt <= `I2CS_BIT_ZERO;
      r.shreg <= 8'h00;
      r.ack_phase <= 1'b0;
      r.master_nack <= 1'b1;
      r.sda_drive <= 1'b0;
      r.pend_code <= 8'h00;
      r.cmd_strobe <= 1'b0;
      r.cmd_code <= 8'h00;
      r.cmd_param <= 8'h00;
      r.cmd_has_param <= 1'b0;
      r.rd_ptr <= PTR_RESET;
      r.dev_reset <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = r.sda_drive;
  assign param_code = r.pend_code;
  assign param_byte = r.shreg;
  assign cmd_strobe = r.cmd_strobe;
  assign cmd_code = r.cmd_code;
  assign cmd_param = r.cmd_param;
  assign cmd_has_param = r.cmd_has_param;
  assign device_reset = r.dev_reset;
  assign read_pointer = r.rd_ptr;
endmodule // i2cs_port

// ===== hw/i2cs_map.svh
// register-free constant map of the two-wire command port
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define I2CS_CMD_DEVICE_RESET 8'hf0
`define I2CS_CMD_SET_READ_POINTER 8'he1
`define I2CS_CMD_WRITE_CONFIG 8'hd2
`define I2CS_CMD_ADJUST_PORT 8'hc3
`define I2CS_CMD_LINE_RESET 8'hb4
`define I2CS_CMD_LINE_SINGLE_BIT 8'h87
`define I2CS_CMD_LINE_WRITE_BYTE 8'ha5
`define I2CS_CMD_LINE_READ_BYTE 8'h96
`define I2CS_CMD_LINE_TRIPLET 8'h78

// ----------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_BIT_ZERO 4'h0
`define I2CS_DIR_READ 1'b1

`endif

// ===== hw/i2cs_pkg.sv
// types shared by the two-wire command port modules
package i2cs_pkg;

  // ----------------------------------------------------------------
  // frame states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    I2CS_IDLE,
    I2CS_ADDR,
    I2CS_W_CMD,
    I2CS_W_PARAM,
    I2CS_W_SURPLUS,
    I2CS_R_DATA,
    I2CS_IGNORE
  } i2cs_state_t;

  // ----------------------------------------------------------------
  // whole state of the core
  // ----------------------------------------------------------------
  typedef struct packed {
    i2cs_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic ack_phase;
    logic master_nack;
    logic sda_drive;
    logic [7:0] pend_code;
    logic cmd_strobe;
    logic [7:0] cmd_code;
    logic [7:0] cmd_param;
    logic cmd_has_param;
    logic [7:0] rd_ptr;
    logic dev_reset;
  } i2cs_core_t;

  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
  } i2cs_sync_t;

endpackage

// ===== hw/i2cs_if.sv
// internal carrier between line synchroniser, decoder and core
`timescale 1ns/1ns
interface i2cs_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_in;
  logic [7:0] code;
  logic known;
  logic has_param;
  logic busy_check;

  modport sync (output scl_rise, output scl_fall, output start, output stop, output sda_in);
  modport dec (input code, output known, output has_param, output busy_check);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda_in,
                output code, input known, input has_param, input busy_check);
endinterface

// ===== hw/i2cs_line_sync.sv
// two-flop synchroniser and edge / condition detector for the bus pins
`timescale 1ns/1ns
module i2cs_line_sync
  import i2cs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  // events
  i2cs_if.sync ev
);
  import i2cs_pkg::*;

  i2cs_sync_t r;
  i2cs_sync_t next_r;

  always_comb begin
    next_r = r;
    next_r.scl1 = scl_i;
    next_r.scl2 = r.scl1;
    next_r.scl3 = r.scl2;
    next_r.sda1 = sda_i;
    next_r.sda2 = r.sda1;
    next_r.sda3 = r.sda2;
  end

  // idle bus is high on both lines
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  // only stages two and three are looked at
  assign ev.scl_rise = r.scl2 & ~r.scl3;
  assign ev.scl_fall = ~r.scl2 & r.scl3;
  assign ev.start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign ev.stop = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  assign ev.sda_in = r.sda2;
endmodule // i2cs_line_sync

// ===== hw/i2cs_cmd_dec.sv
// command code classifier
`timescale 1ns/1ns
`include "i2cs_map.svh"
module i2cs_cmd_dec
  import i2cs_pkg::*;
(
  // classification port
  i2cs_if.dec dc
);
  import i2cs_pkg::*;

  always_comb begin
    dc.known = 1'b1;
    dc.has_param = 1'b0;
    dc.busy_check = 1'b1;
    case (dc.code)
      `I2CS_CMD_DEVICE_RESET: begin
        dc.busy_check = 1'b0;
      end
      `I2CS_CMD_SET_READ_POINTER: begin
        dc.has_param = 1'b1;
        dc.busy_check = 1'b0;
      end
      `I2CS_CMD_WRITE_CONFIG: begin
        dc.has_param = 1'b1;
      end
      `I2CS_CMD_LINE_RESET, `I2CS_CMD_LINE_READ_BYTE: begin
        dc.has_param = 1'b0;
      end
      `I2CS_CMD_LINE_SINGLE_BIT, `I2CS_CMD_LINE_WRITE_BYTE, `I2CS_CMD_LINE_TRIPLET,
      `I2CS_CMD_ADJUST_PORT: begin
        dc.has_param = 1'b1;
      end
      default: begin
        dc.known = 1'b0;
        dc.busy_check = 1'b0;
      end
    endcase
  end
endmodule // i2cs_cmd_dec

// ===== testbench/i2cs_port_chk.sv
// concurrent checks on the ports of the two-wire command port
`timescale 1ns/1ns
module i2cs_port_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // command side
  input wire logic line_busy_flag,
  input wire logic [7:0] param_code,
  input wire logic [7:0] param_byte,
  input wire logic param_ok,
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param,
  input wire logic cmd_has_param,
  input wire logic device_reset,
  input wire logic [7:0] read_pointer,
  input wire logic [7:0] read_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence scl_high4;
    scl_i [*4];
  endsequence
  sequence e1_taken;
    cmd_strobe && cmd_code == 8'he1;
  endsequence
  odrain_a: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  strobe_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("strobe longer than one cycle");
  reset_pair_a: assert property (device_reset == (cmd_strobe && cmd_code == 8'hf0))
    else $error("device reset pulse mismatch");
  param_map_a: assert property (
    cmd_strobe |-> cmd_has_param == (cmd_code inside {8'he1, 8'hd2, 8'hc3, 8'h87, 8'ha5, 8'h78}))
    else $error("parameter flag wrong for code");
  param_echo_a: assert property (cmd_strobe && cmd_has_param |-> cmd_param == param_byte)
    else $error("parameter not the received byte");
  ptr_load_a: assert property (e1_taken |=> read_pointer == $past(cmd_param))
    else $error("read pointer not loaded");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("sda pull dropped early");
  low_change_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda changed while scl high");
  high_quiet_a: assert property (scl_high4 |-> $stable(sda_oe))
    else $error("sda moved in scl high phase");
  param_code_a: assert property (cmd_strobe && cmd_has_param |-> param_code == cmd_code)
    else $error("parameter held for wrong code");
  param_gate_a: assert property (cmd_strobe && cmd_has_param |-> $past(param_ok))
    else $error("refused parameter was accepted");
  busy_gate_a: assert property (
    cmd_strobe && !cmd_has_param && cmd_code != 8'hf0 |-> !$past(line_busy_flag))
    else $error("line command accepted while busy");
endmodule // i2cs_port_chk

bind i2cs_port i2cs_port_chk chk (.clk_sys, .rst, .scl_i, .sda_i, .sda_o, .sda_oe, .line_busy_flag,
  .param_code, .param_byte, .param_ok, .cmd_strobe, .cmd_code, .cmd_param, .cmd_has_param,
  .device_reset, .read_pointer, .read_data);

// ===== testbench/i2cs_master_model.sv
// bit-banged two-wire bus master, scl period 160 ns
`timescale 1ns/1ns
module i2cs_master_model (
  // bus
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // scl idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // release, raise scl, then pull: a start even from mid byte
  task automatic start;
    sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask
  // data only moves in the low phase, sampled mid high
  task automatic bitx(input logic b, output logic r);
    #40 sda_pull = ~b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int j = 7; j >= 0; j--) bitx(b[j], r);
    bitx(1'b1, ack);
  endtask
  // sda is released for every read bit; nak ends the read
  task automatic rbyte(input logic nak, output logic [7:0] b);
    logic r;
    for (int j = 7; j >= 0; j--) bitx(1'b1, b[j]);
    bitx(nak, r);
  endtask
endmodule // i2cs_master_model

// ===== testbench/tb.sv
// self-checking bench of the two-wire command port
`timescale 1ns/1ns
module tb;
  import i2cs_pkg::*;
  localparam logic [7:0] AW = 8'h54;
  logic clk_sys = 0, rst = 1, line_busy_flag = 0, param_ok = 1;
  logic [7:0] read_data = 8'h00;
  logic scl, pull, sda_oe, sda_o, cmd_strobe, cmd_has_param, device_reset;
  logic [7:0] cmd_code, cmd_param, read_pointer;
  wire sda = !(pull || sda_oe === 1'b1); // pull-up when nobody pulls
  int error_cnt = 0, comparisons = 0, seed = 44227;
  logic [16:0] exp_q[$];
  logic [7:0] codes[9] = '{8'hf0, 8'hb4, 8'h96, 8'he1, 8'hd2, 8'hc3, 8'h87, 8'ha5, 8'h78};
  always #5 clk_sys = ~clk_sys;
  i2cs_port uut (.clk_sys, .rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .line_busy_flag,
    .param_code(), .param_byte(), .param_ok, .cmd_strobe, .cmd_code, .cmd_param, .cmd_has_param,
    .device_reset, .read_pointer, .read_data);
  i2cs_master_model m (.scl, .sda_pull(pull), .sda);
  always @(posedge clk_sys) read_data <= read_pointer ^ 8'h5a;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // every accepted command is noted in order and matched here
  // looked at mid-cycle, so the strobe and its fields have settled
  always @(negedge clk_sys) if (cmd_strobe === 1'b1) begin
    if (exp_q.size() == 0) chk(1, 0, "unexpected strobe");
    else chk({device_reset, cmd_code, cmd_param & {8{cmd_has_param}}}, exp_q.pop_front(), "command");
  end
  task automatic frame(input logic [7:0] b[4], input int n, input logic [3:0] ea);
    logic ack;
    // keep every pin change of the master off the sampling edge
    @(negedge clk_sys);
    m.start();
    for (int i = 0; i < n; i++) begin
      m.wbyte(b[i], ack);
      chk(ack, ea[3-i], "ack bit");
    end
    m.stop();
  endtask
  // read n bytes of the pointed register, nak on the last one
  task automatic rd(input int n, input logic [7:0] e);
    logic ack;
    logic [7:0] b;
    @(negedge clk_sys);
    m.start();
    m.wbyte(AW | 8'h01, ack);
    chk(ack, 0, "read address");
    for (int k = 0; k < n; k++) begin
      m.rbyte(k == n - 1, b);
      chk(b, e, "read byte");
    end
    // give the port time to reload wrongly before looking
    repeat (4) @(negedge clk_sys);
    chk(sda, 1, "released after nak");
    m.stop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] p, pe;
    logic r;
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    repeat (3) @(posedge clk_sys);
    foreach (codes[i]) begin
      p = 8'($random(seed));
      if (codes[i] == 8'he1) pe = p;
      exp_q.push_back({codes[i] == 8'hf0, codes[i], i > 2 ? p : 8'h00});
      frame('{AW, codes[i], p, 8'h00}, i > 2 ? 3 : 2, 4'b0000);
    end
    @(posedge clk_sys) line_busy_flag <= 1;
    frame('{AW, 8'hb4, 8'h00, 8'h00}, 2, 4'b0100);
    frame('{AW, 8'h87, 8'h01, 8'h00}, 3, 4'b0110);
    pe = 8'($random(seed));
    exp_q.push_back({1'b0, 8'he1, pe});
    frame('{AW, 8'he1, pe, 8'h00}, 3, 4'b0000);
    @(posedge clk_sys) line_busy_flag <= 0;
    param_ok <= 0;
    frame('{AW, 8'hd2, 8'h33, 8'h00}, 3, 4'b0010);
    @(posedge clk_sys) param_ok <= 1;
    exp_q.push_back({1'b0, 8'ha5, 8'h3c});
    frame('{AW, 8'ha5, 8'h3c, 8'h3c}, 4, 4'b0001);
    frame('{8'h56, 8'hb4, 8'h00, 8'h00}, 2, 4'b1100);
    // abandoned byte, then a repeated start carries a whole command
    m.start();
    for (int j = 7; j > 3; j--) m.bitx(AW[j], r);
    exp_q.push_back({1'b1, 8'hf0, 8'h00});
    frame('{AW, 8'hf0, 8'h00, 8'h00}, 2, 4'b0000);
    // device reset puts the pointer back to its reset value of zero
    rd(3, 8'h00 ^ 8'h5a);
    pe = 8'($random(seed));
    exp_q.push_back({1'b0, 8'he1, pe});
    frame('{AW, 8'he1, pe, 8'h00}, 3, 4'b0000);
    rd(2, pe ^ 8'h5a);
    repeat (5) @(posedge clk_sys);
    chk(17'(exp_q.size()), 0, "missing strobes");
    wrap_up();
  end
  initial begin
    // the scenarios need about 8.2k cycles; this allows over three times that
    #300000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb
